// file: design/sfos_defs.svh
// Constants for the serial flash security-area and status read block
`ifndef SFOS_DEFS_SVH
`define SFOS_DEFS_SVH

// Command opcodes
`define SFOS_OP_READ_OTP      8'h77
`define SFOS_OP_READ_STATUS   8'h05
`define SFOS_OP_WRITE_STATUS1 8'h01

// Byte counts of the security-area read header (count minus one)
`define SFOS_ADDR_LAST        2'h2
`define SFOS_DUMMY_LAST       2'h1

// Security-area bounds and address step
`define SFOS_OTP_BYTES        128
`define SFOS_OTP_STEP         7'h01

// Status byte one field positions
`define SFOS_BIT_LOCK         7
`define SFOS_BIT_RSVD         6
`define SFOS_BIT_ERROR        5
`define SFOS_BIT_PIN          4
`define SFOS_BIT_SWP_HI       3
`define SFOS_BIT_SWP_LO       2
`define SFOS_BIT_WEL          1
`define SFOS_BIT_BUSY         0

// Reset values, reserved bit value and last bit index
`define SFOS_LOCK_RST         1'h0
`define SFOS_ERROR_RST        1'h0
`define SFOS_RSVD_VAL         1'h0
`define SFOS_BYTE_RST         8'h00
`define SFOS_BIT_LAST         3'h7

`endif

// file: design/sfos_pkg.sv
// Types shared by the serial flash security-area and status read block
package sfos_pkg;
  // Link-side command phases
  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_OTP,
    PH_STATUS,
    PH_WRITE1,
    PH_IGNORE
  } sfos_phase_t;

  // Both status bytes as one snapshot
  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
  } sfos_status_t;

  // Report of a finished program or erase operation
  typedef struct packed {
    logic done;
    logic error;
    logic aborted;
  } sfos_op_t;
endpackage

// file: design/sfos_top.sv
// Serial flash command logic: security-area read and status read
`include "sfos_defs.svh"

module sfos_top #(
  parameter int OTP_BYTES = `SFOS_OTP_BYTES,
  parameter int OTP_AW    = $clog2(OTP_BYTES)
) (
  // System clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Device state from the rest of the flash
  input  wire logic               i_busy,
  input  wire logic               i_write_enable_latch,
  input  wire logic [1:0]         i_software_protect_summary,
  input  sfos_pkg::sfos_op_t      i_op,
  input  wire logic [7:0]         i_status_two,
  // Write-protect pin, active low
  input  wire logic               i_protect_pin_n,
  // Security-area content load
  input  wire logic               i_otp_we,
  input  wire logic [OTP_AW-1:0]  i_otp_addr,
  input  wire logic [7:0]         i_otp_data,
  // Serial link
  input  wire logic               i_sck,
  input  wire logic               i_cs_n,
  input  wire logic               i_si,
  output logic                    o_so,
  output logic                    o_so_oe,
  // Status towards the rest of the flash
  output logic                    o_protection_lock,
  output logic                    o_program_error_flag,
  output logic                    o_status_write_done
);
  import sfos_pkg::*;

  // ---------------- System clock domain ----------------

  logic               pin_s1_r;        // Pin synchroniser, first stage
  logic               pin_s2_r;        // Pin synchroniser, second stage
  logic               lock_r;          // Protection lock
  logic               lock_nxt;
  logic               err_r;           // Program error flag
  logic               err_nxt;
  logic               link_rst_r;      // Reset towards link domain
  sfos_status_t       snap_r;          // Snapshot offered to link
  logic               req_r;           // Snapshot offer toggle
  logic               ack_s1_r;        // Ack synchroniser, first stage
  logic               ack_s2_r;        // Ack synchroniser, second stage
  logic               wt_s1_r;         // Write toggle sync, first stage
  logic               wt_s2_r;         // Write toggle sync, second stage
  logic               wt_s3_r;         // Write toggle, edge reference
  logic               wr_done_r;       // Pulse per status write, blocked or not
  logic [7:0]         otp_mem [OTP_BYTES]; // Security-area storage

  sfos_status_t       live;            // Current status, both bytes
  wire logic          snap_free;       // Link has taken last snapshot
  wire logic          wr_event;        // Status write arrived
  wire logic          pin_asserted;    // Protect pin active
  logic               wr_bit_r;        // Lock value from link domain
  logic               wr_tgl_r;        // Write toggle from link domain
  logic               ack_r;           // Link-side ack toggle

  assign snap_free    = (ack_s2_r == req_r);
  assign wr_event     = wt_s2_r ^ wt_s3_r;
  assign pin_asserted = ~pin_s2_r;

  // Status byte one assembly, busy copied into byte two
  always_comb begin
    live.one                  = `SFOS_BYTE_RST;
    live.one[`SFOS_BIT_LOCK]  = lock_r;
    live.one[`SFOS_BIT_RSVD]  = `SFOS_RSVD_VAL;
    live.one[`SFOS_BIT_ERROR] = err_r;
    live.one[`SFOS_BIT_PIN]   = pin_s2_r;
    live.one[`SFOS_BIT_SWP_HI:`SFOS_BIT_SWP_LO] =
      i_software_protect_summary;
    live.one[`SFOS_BIT_WEL]   = i_write_enable_latch;
    live.one[`SFOS_BIT_BUSY]  = i_busy;
    live.two                  = i_status_two;
    live.two[`SFOS_BIT_BUSY]  = i_busy;
  end

  // Lock update: only bit 7 is touched by a status write
  always_comb begin
    lock_nxt = lock_r;
    if (wr_event && (!pin_asserted || wr_bit_r)) begin
      // Pin asserted allows only a set
      lock_nxt = wr_bit_r;
    end
  end

  // Error flag: refreshed per operation, aborts never set it
  always_comb begin
    err_nxt = err_r;
    if (i_op.done) begin
      err_nxt = i_op.error & ~i_op.aborted;
    end
  end

  // Pin and toggle synchronisers
  always_ff @(posedge i_clk) begin
    pin_s1_r <= i_protect_pin_n;
    pin_s2_r <= pin_s1_r;
    ack_s1_r <= ack_r;
    ack_s2_r <= ack_s1_r;
    wt_s1_r  <= wr_tgl_r;
    wt_s2_r  <= wt_s1_r;
  end

  // Lock, error flag and write reporting
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lock_r     <= `SFOS_LOCK_RST;
      err_r      <= `SFOS_ERROR_RST;
      wt_s3_r    <= 1'h0;
      wr_done_r  <= 1'h0;
      link_rst_r <= 1'h1;
    end else begin
      lock_r     <= lock_nxt;
      err_r      <= err_nxt;
      wt_s3_r    <= wt_s2_r;
      wr_done_r  <= wr_event;
      link_rst_r <= 1'h0;
    end
  end

  // Snapshot offer: held steady until the link echoes the toggle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      snap_r <= '0;
      req_r  <= 1'h0;
    end else if (snap_free) begin
      snap_r <= live;
      req_r  <= ~req_r;
    end
  end

  // Security-area storage, filled from the system side
  always_ff @(posedge i_clk) begin
    if (i_otp_we) begin
      otp_mem[i_otp_addr] <= i_otp_data;
    end
  end

  assign o_protection_lock    = lock_r;
  assign o_program_error_flag = err_r;
  assign o_status_write_done  = wr_done_r;

  // ---------------- Link clock domain ----------------

  sfos_phase_t        phase_r;         // Command phase
  sfos_phase_t        phase_nxt;
  logic [2:0]         bit_r;           // Bits taken in current byte
  logic [1:0]         cnt_r;           // Header byte count
  logic [1:0]         cnt_nxt;
  logic [6:0]         shin_r;          // Incoming bits
  logic [OTP_AW-1:0]  addr_r;          // Next security location
  logic [OTP_AW-1:0]  addr_nxt;
  logic [7:0]         tx_r;            // Byte being shifted out
  logic [7:0]         tx_nxt;
  logic               sel_r;           // Next status byte is byte two
  logic               sel_nxt;
  logic               req_k1_r;        // Offer sync, first stage
  logic               req_k2_r;        // Offer sync, second stage
  sfos_status_t       stat_r;          // Captured status snapshot
  logic               so_r;            // Serial output bit
  logic               oe_r;            // Serial output enable

  wire logic          byte_done;       // Eighth bit of a byte now
  wire logic [7:0]    rx_byte;         // Completed incoming byte
  wire logic          data_phase;      // Output driven in this phase

  assign byte_done  = (bit_r == `SFOS_BIT_LAST);
  assign rx_byte    = {shin_r, i_si};
  assign data_phase = (phase_r == PH_OTP) || (phase_r == PH_STATUS);

  // Command sequencing, evaluated at each byte end
  always_comb begin
    phase_nxt = phase_r;
    cnt_nxt   = cnt_r;
    addr_nxt  = addr_r;
    tx_nxt    = tx_r;
    sel_nxt   = sel_r;
    if (byte_done) begin
      case (phase_r)
        PH_OPCODE: begin
          if (rx_byte == `SFOS_OP_READ_OTP) begin
            phase_nxt = PH_ADDR;
            cnt_nxt   = 2'h0;
          end else if (rx_byte == `SFOS_OP_READ_STATUS) begin
            // Byte one first, no header bytes
            phase_nxt = PH_STATUS;
            tx_nxt    = stat_r.one;
            sel_nxt   = 1'h1;
          end else if (rx_byte == `SFOS_OP_WRITE_STATUS1) begin
            phase_nxt = PH_WRITE1;
          end else begin
            // Unknown opcodes are ignored until select rises
            phase_nxt = PH_IGNORE;
          end
        end
        PH_ADDR: begin
          if (cnt_r == `SFOS_ADDR_LAST) begin
            // Upper address bits fall outside the area
            addr_nxt  = rx_byte[OTP_AW-1:0];
            phase_nxt = PH_DUMMY;
            cnt_nxt   = 2'h0;
          end else begin
            cnt_nxt   = cnt_r + 2'h1;
          end
        end
        PH_DUMMY: begin
          if (cnt_r == `SFOS_DUMMY_LAST) begin
            phase_nxt = PH_OTP;
            tx_nxt    = otp_mem[addr_r];
            addr_nxt  = addr_r + OTP_AW'(`SFOS_OTP_STEP);
          end else begin
            cnt_nxt   = cnt_r + 2'h1;
          end
        end
        PH_OTP: begin
          // Natural overflow wraps last location to zero
          tx_nxt   = otp_mem[addr_r];
          addr_nxt = addr_r + OTP_AW'(`SFOS_OTP_STEP);
        end
        PH_STATUS: begin
          // Fresh snapshot for every byte
          tx_nxt  = sel_r ? stat_r.two : stat_r.one;
          sel_nxt = ~sel_r;
        end
        PH_WRITE1: begin
          phase_nxt = PH_IGNORE;
        end
        default: begin
          phase_nxt = PH_IGNORE;
        end
      endcase
    end
  end

  // Link state, cleared whenever select is released
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      phase_r <= PH_OPCODE;
      bit_r   <= 3'h0;
      cnt_r   <= 2'h0;
      shin_r  <= 7'h00;
      addr_r  <= '0;
      tx_r    <= `SFOS_BYTE_RST;
      sel_r   <= 1'h0;
    end else begin
      phase_r <= phase_nxt;
      bit_r   <= bit_r + 3'h1;
      cnt_r   <= cnt_nxt;
      shin_r  <= rx_byte[6:0];
      addr_r  <= addr_nxt;
      tx_r    <= tx_nxt;
      sel_r   <= sel_nxt;
    end
  end

  // Snapshot capture; link clock only runs in frames, so the
  // first bytes of a frame may carry an old snapshot
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      req_k1_r <= 1'h0;
      req_k2_r <= 1'h0;
      ack_r    <= 1'h0;
      stat_r   <= '0;
    end else begin
      req_k1_r <= req_r;
      req_k2_r <= req_k1_r;
      ack_r    <= req_k2_r;
      if (req_k2_r != ack_r) begin
        stat_r <= snap_r;
      end
    end
  end

  // Status write capture; kept across frames so the toggle survives
  always_ff @(posedge i_sck or posedge link_rst_r) begin
    if (link_rst_r) begin
      wr_tgl_r <= 1'h0;
      wr_bit_r <= `SFOS_LOCK_RST;
    end else if ((phase_r == PH_WRITE1) && byte_done) begin
      wr_bit_r <= rx_byte[`SFOS_BIT_LOCK];
      wr_tgl_r <= ~wr_tgl_r;
    end
  end

  // Output launches on the falling edge, floats outside data
  always_ff @(negedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      so_r <= 1'h0;
      oe_r <= 1'h0;
    end else begin
      so_r <= tx_r[~bit_r];
      oe_r <= data_phase;
    end
  end

  assign o_so    = so_r;
  assign o_so_oe = oe_r;
endmodule

// file: tb/sfos_assertions.sv
// Checker of link framing and status flag behaviour
`include "sfos_defs.svh"
module sfos_assertions (
  // Clock and reset
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  // Watched inputs
  input  wire logic          i_sck,
  input  wire logic          i_cs_n,
  input  wire logic          i_si,
  input  wire logic          i_protect_pin_n,
  input  sfos_pkg::sfos_op_t i_op,
  // Watched outputs
  input  wire logic          o_so_oe,
  input  wire logic          o_protection_lock,
  input  wire logic          o_program_error_flag,
  input  wire logic          o_status_write_done
);
  timeunit 1ns;
  timeprecision 100ps;
  import sfos_pkg::*;
  logic [6:0] edges_r; // Rising link edges this frame, saturating
  logic [7:0] op_r;    // Opcode as shifted in
  wire        op_in = edges_r >= 7'h08; // Opcode complete
  // Count edges and catch the opcode; select high clears both
  always_ff @(posedge i_sck or posedge i_cs_n) begin
    if (i_cs_n) begin
      edges_r <= 7'h00;
      op_r    <= 8'h00;
    end else begin
      edges_r <= edges_r + {6'h00, edges_r != 7'h7F};
      if (!op_in) op_r <= {op_r[6:0], i_si};
    end
  end
  hdr_float_a: assert property (
    @(posedge i_sck) disable iff (i_cs_n) !op_in |-> !o_so_oe)
    else $error("output driven during opcode");
  stat_drive_a: assert property (
    @(posedge i_sck) disable iff (i_cs_n)
    op_in && op_r == `SFOS_OP_READ_STATUS |-> o_so_oe)
    else $error("status data not driven");
  otp_gap_a: assert property (
    @(posedge i_sck) disable iff (i_cs_n) op_r == `SFOS_OP_READ_OTP
    && edges_r < 7'h30 |-> !o_so_oe) else $error("early security data");
  otp_drive_a: assert property (
    @(posedge i_sck) disable iff (i_cs_n) op_r == `SFOS_OP_READ_OTP
    && edges_r >= 7'h30 |-> o_so_oe) else $error("security data missing");
  odd_op_a: assert property (
    @(posedge i_sck) disable iff (i_cs_n) op_in && op_r !=
    `SFOS_OP_READ_STATUS && op_r != `SFOS_OP_READ_OTP |-> !o_so_oe)
    else $error("output driven for other command");
  oe_select_a: assert property (
    @(posedge i_clk) disable iff (i_rst) i_cs_n |-> !o_so_oe)
    else $error("output driven while deselected");
  err_set_a: assert property (
    @(posedge i_clk) disable iff (i_rst) i_op.done && i_op.error
    && !i_op.aborted |=> o_program_error_flag) else $error("error not set");
  err_abort_a: assert property (
    @(posedge i_clk) disable iff (i_rst) i_op.done && i_op.aborted
    |=> !o_program_error_flag) else $error("error set by abort");
  err_hold_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !i_op.done |=> $stable(o_program_error_flag))
    else $error("error flag moved without operation");
  lock_cause_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !$stable(o_protection_lock) |-> o_status_write_done)
    else $error("lock moved without write");
  lock_pin_a: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (!i_protect_pin_n) [*8] |=> !$fell(o_protection_lock))
    else $error("lock cleared while pin asserted");
endmodule
bind sfos_top sfos_assertions i_sfos_assertions (
  .i_clk(i_clk), .i_rst(i_rst), .i_sck(i_sck), .i_cs_n(i_cs_n),
  .i_si(i_si), .i_protect_pin_n(i_protect_pin_n), .i_op(i_op),
  .o_so_oe(o_so_oe), .o_protection_lock(o_protection_lock),
  .o_program_error_flag(o_program_error_flag),
  .o_status_write_done(o_status_write_done));

// file: tb/sfos_host.sv
// Host model driving select, link clock and command bytes
module sfos_host (
  // Link towards the device
  output logic      o_sck,
  output logic      o_cs_n,
  output logic      o_si,
  input  wire logic i_so,
  input  wire logic i_so_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle link: clock still and low between frames
  initial begin
    o_sck  = 1'b0;
    o_si   = 1'b0;
    // Select rises after time zero so the link logic sees a clean edge
    #1 o_cs_n = 1'b1;
  end
  // Odd offset keeps the link out of phase with the system clock
  task automatic open_frame();
    #3.3 o_cs_n = 1'b0;
    #62.5;
  endtask
  // Shift n bits MSB first; a floating output reads as unknown
  task automatic shift(input logic [7:0] b, input int n,
                       output logic [7:0] r);
    r = 8'hxx;
    for (int i = 7; i > 7 - n; i--) begin
      o_si = b[i];
      #62.5 o_sck = 1'b1;
      r[i] = i_so_oe ? i_so : 1'bx;
      #62.5 o_sck = 1'b0;
    end
  endtask
  // Release select; data line no longer holds the last bit
  task automatic close_frame();
    #62.5 o_cs_n = 1'b1;
    o_si = ~o_si;
  endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the security-area and status read block
`include "sfos_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sfos_pkg::*;
  // Design inputs and outputs
  logic       clk = 1'b0, rst = 1'b1, busy = 1'b0, write_enable_latch = 1'b0;
  logic       pin_n = 1'b1, otp_we = 1'b0;
  logic [1:0] software_protect_summary = 2'h0;
  logic [6:0] otp_addr = 7'h00;
  logic [7:0] otp_data = 8'h00, st_two = 8'h00, rb;
  sfos_op_t   op = '0;
  logic       sck, cs_n, si, so, so_oe, lock, err, wd;
  // Expected state and counters
  logic       exp_lock = 1'b0, exp_err = 1'b0;
  int         n_errors = 0, checked = 0, n_wd = 0;
  sfos_top i_sfos_top (
    .i_clk(clk), .i_rst(rst), .i_busy(busy), .i_write_enable_latch(write_enable_latch),
    .i_software_protect_summary(software_protect_summary), .i_op(op), .i_status_two(st_two),
    .i_protect_pin_n(pin_n), .i_otp_we(otp_we), .i_otp_addr(otp_addr),
    .i_otp_data(otp_data), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
    .o_so(so), .o_so_oe(so_oe), .o_protection_lock(lock),
    .o_program_error_flag(err), .o_status_write_done(wd));
  sfos_host i_sfos_host (
    .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));
  // System clock, 100 MHz
  always #5 clk = ~clk;
  // Count write completions; the pulse lasts one cycle only
  always @(posedge clk) if (wd === 1'b1) n_wd++;
  // Security contents pattern
  function automatic logic [7:0] otp_val(input logic [6:0] a);
    return {1'b0, a} ^ 8'hC3;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One byte across the link, compared with what should come back
  task automatic xb(input logic [7:0] b, input logic [7:0] exp);
    i_sfos_host.shift(b, 8, rb);
    check(rb, exp);
  endtask
  // Stale bytes skipped before each of two checked pairs; busy flips in mid-frame
  task automatic status_read();
    i_sfos_host.open_frame();
    xb(`SFOS_OP_READ_STATUS, 8'hxx);
    for (int k = 0; k < 2; k++) begin
      repeat (2) i_sfos_host.shift(8'h00, 8, rb);
      xb(8'h00, {exp_lock, 1'b0, exp_err, pin_n, software_protect_summary, write_enable_latch, busy});
      xb(8'h00, {st_two[7:1], busy});
      @(posedge clk) #1 busy = ~busy;
    end
    i_sfos_host.close_frame();
    #1 check({7'h00, so_oe}, 8'h00);
  endtask
  // Header leaves the output floating; data wraps past 7Fh
  task automatic otp_read(input logic [6:0] a);
    i_sfos_host.open_frame();
    xb(`SFOS_OP_READ_OTP, 8'hxx);
    for (int k = 0; k < 2; k++) xb(8'hFF, 8'hxx);
    xb({1'b1, a}, 8'hxx);
    repeat (2) xb(8'h00, 8'hxx);
    for (int k = 0; k < 4; k++) xb(8'h00, otp_val(a + 7'(k)));
    i_sfos_host.shift(8'h00, 3, rb);
    i_sfos_host.close_frame();
    #1 check({7'h00, so_oe}, 8'h00);
  endtask
  // Status byte one write; pulse count checked only when p is set, though blocked writes pulse too
  task automatic wr1(input logic [7:0] b, input logic p);
    int w0;
    w0 = n_wd;
    i_sfos_host.open_frame();
    xb(`SFOS_OP_WRITE_STATUS1, 8'hxx);
    xb(b, 8'hxx);
    i_sfos_host.close_frame();
    for (int t = 0; t < 50 && n_wd == w0; t++) @(posedge clk);
    #1 if (p) check(8'(n_wd - w0), 8'h01);
    check({7'h00, lock}, {7'h00, exp_lock});
  endtask
  // One finished operation report, then the flag read back
  task automatic op_done(input logic e, input logic a);
    @(posedge clk) #1 op = '{done: 1'b1, error: e, aborted: a};
    @(posedge clk) #1 op = '0;
    exp_err = e & ~a;
    check({7'h00, err}, {7'h00, exp_err});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    check({6'h00, lock, err}, 8'h00);
    for (int a = 0; a < 128; a++) begin
      @(posedge clk) #1 otp_we = 1'b1;
      otp_addr = 7'(a);
      otp_data = otp_val(7'(a));
    end
    @(posedge clk) #1 otp_we = 1'b0;
    otp_read(7'h7E);
    otp_read(7'h10);
    $display("test security read done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) #1 software_protect_summary = 2'(i);
      write_enable_latch = i[0];
      pin_n = ~i[0];
      st_two = 8'h5A ^ 8'(i);
      status_read();
    end
    $display("test status read done");
    @(posedge clk) #1 pin_n = 1'b1;
    exp_lock = 1'b1;
    wr1(8'hFF, 1'b1);
    @(posedge clk) #1 pin_n = 1'b0;
    wr1(8'h00, 1'b0);
    status_read();
    @(posedge clk) #1 pin_n = 1'b1;
    exp_lock = 1'b0;
    wr1(8'h7F, 1'b1);
    $display("test status write done");
    op_done(1'b1, 1'b0);
    op_done(1'b1, 1'b1);
    op_done(1'b1, 1'b0);
    op_done(1'b0, 1'b0);
    $display("test error flag done");
    i_sfos_host.open_frame();
    repeat (2) xb(8'h3C, 8'hxx);
    i_sfos_host.close_frame();
    #1 check({7'h00, so_oe}, 8'h00);
    $display("test unknown command done");
    give_verdict();
  end
  // Watchdog: several times the expected run of about 76 us
  initial begin
    #400000;
    n_errors++;
    give_verdict();
  end
endmodule
